// ===== rtl/sos_defines.svh
// constants of the status output selector: offsets, fields, codes, reset values, timing
`ifndef SOS_DEFINES_SVH
`define SOS_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define SOS_OFS_CTRL 8'h00
`define SOS_OFS_START_FREQ 8'h04
`define SOS_OFS_FREQ_DETECT_LEVEL 8'h08
`define SOS_OFS_CURRENT_DETECT_LEVEL 8'h0C
`define SOS_OFS_CURRENT_DETECT_TIMER 8'h10
`define SOS_OFS_THERMAL_WARN_LEVEL 8'h14
`define SOS_OFS_EVENT_STATUS 8'h18
`define SOS_OFS_EVENT_MASK 8'h1C
`define SOS_OFS_LIVE_STATUS 8'h20

// ****************************************
// field positions and widths
// ****************************************
`define SOS_ADDR_W 8
`define SOS_VAL_W 16
`define SOS_SEL_W 7
`define SOS_CTRL_SEL_LSB 0
`define SOS_CTRL_INV_BIT 8
`define SOS_EVT_W 4
`define SOS_EVT_SELECTED 0
`define SOS_EVT_OVERCUR 1
`define SOS_EVT_UNDERCUR 2
`define SOS_EVT_FAULT 3
`define SOS_LIVE_ACTIVE 0
`define SOS_LIVE_TERMINAL 1
`define SOS_LIVE_ARRIVAL 2
`define SOS_LIVE_FREQ_DET 3
`define SOS_LIVE_OVERCUR 4
`define SOS_LIVE_UNDERCUR 5

// ****************************************
// selector codes
// ****************************************
`define SOS_SEL_RUNNING 7'h00
`define SOS_SEL_FREQ_ARRIVAL 7'h01
`define SOS_SEL_FREQ_LEVEL 7'h02
`define SOS_SEL_UNDERVOLTAGE 7'h03
`define SOS_SEL_CURRENT_LIMIT 7'h05
`define SOS_SEL_AUTO_RESTART 7'h06
`define SOS_SEL_THERMAL_WARN 7'h07
`define SOS_SEL_AUTO_RESET 7'h1A
`define SOS_SEL_SERVICE_AGE 7'h1E
`define SOS_SEL_GATE_ON 7'h23
`define SOS_SEL_OVERLOAD_AVOID 7'h24
`define SOS_SEL_OVERCURRENT 7'h25
`define SOS_SEL_UNDERCURRENT 7'h29
`define SOS_SEL_ANY_FAULT 7'h63

// ****************************************
// reset values
// ****************************************
`define SOS_RST_SEL 7'h00
`define SOS_RST_INV 1'h0
`define SOS_RST_VAL 16'h0000
`define SOS_RST_EVT 4'h0

// ****************************************
// hysteresis (0.1 Hz units) and timing
// ****************************************
`define SOS_ARRIVE_HYST 16'h0019
`define SOS_FDET_HYST 16'h000A
`define SOS_CLK_KHZ 10000
`define SOS_TICK_TIME_US 1000
`define SOS_TICK_CYCLES ((`SOS_TICK_TIME_US * `SOS_CLK_KHZ) / 1000)

`endif

// ===== rtl/sos_pkg.sv
// types of the status output selector
`include "sos_defines.svh"
`default_nettype none

package sos_pkg;

    // ****************************************
    // bus state machines
    // ****************************************
    typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} sos_wr_st_t;
    typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} sos_rd_st_t;

    typedef logic [`SOS_VAL_W-1:0] sos_val_t;

    // ****************************************
    // top state
    // ****************************************
    typedef struct packed {
        sos_wr_st_t wr_st;
        sos_rd_st_t rd_st;
        logic aw_have;
        logic [`SOS_ADDR_W-1:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [`SOS_SEL_W-1:0] sel;
        logic inv;
        sos_val_t start_freq;
        sos_val_t freq_detect_level;
        sos_val_t current_detect_level;
        sos_val_t current_detect_timer;
        sos_val_t thermal_warn_level;
        logic [`SOS_EVT_W-1:0] evt_status;
        logic [`SOS_EVT_W-1:0] evt_mask;
        logic [`SOS_EVT_W-1:0] evt_prev;
        logic active;
        logic terminal;
    } sos_top_st_t;

    // byte-lane merge of a write into a 32-bit word
    function automatic logic [31:0] sos_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : sos_merge

endpackage : sos_pkg

`default_nettype wire

// ===== rtl/sos_if.sv
// carrier between the selector top and its detector block
`default_nettype none

interface sos_det_if;
    logic [15:0] out_freq;
    logic [15:0] set_freq;
    logic run_cmd;
    logic [15:0] current;
    logic [15:0] freq_detect_level;
    logic [15:0] current_detect_level;
    logic [15:0] current_detect_timer;
    logic freq_arrival;
    logic freq_level_detect;
    logic overcurrent_timed_detect;
    logic undercurrent_timed_detect;

    modport ctl (output out_freq, set_freq, run_cmd, current, freq_detect_level, current_detect_level,
                 current_detect_timer, input freq_arrival, freq_level_detect, overcurrent_timed_detect,
                 undercurrent_timed_detect);
    modport det (input out_freq, set_freq, run_cmd, current, freq_detect_level, current_detect_level,
                 current_detect_timer, output freq_arrival, freq_level_detect, overcurrent_timed_detect,
                 undercurrent_timed_detect);
endinterface : sos_det_if

`default_nettype wire

// ===== rtl/sos_detect.sv
// hysteresis and timed detectors feeding the status selector
`include "sos_defines.svh"
`default_nettype none

module sos_detect #(
    parameter int TICK_CYCLES = `SOS_TICK_CYCLES // cycles per timer unit (1 ms)
) (
    input wire logic mclk_i,          // system clock
    input wire logic nrst_i,          // synchronous reset, active low
    sos_det_if.det det                // values in, detector levels out
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    typedef struct packed {
        logic [TW-1:0] tick_cnt;
        logic arrival;
        logic fdet;
        logic [15:0] oc_cnt;
        logic oc_det;
        logic [15:0] uc_cnt;
        logic uc_det;
    } sos_det_st_t;

    sos_det_st_t q;
    sos_det_st_t n;
    logic tick;
    logic [15:0] diff;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        n = q;
        tick = (q.tick_cnt == TICK_LAST);
        n.tick_cnt = tick ? '0 : TW'(q.tick_cnt + 1'b1);
        diff = (det.out_freq >= det.set_freq) ? 16'(det.out_freq - det.set_freq)
                                              : 16'(det.set_freq - det.out_freq);
        // off with no run command; else on at the set point, off only once outside the band, so it does not chatter
        if (!det.run_cmd)
            n.arrival = 1'b0;
        else if (diff == 16'h0000)
            n.arrival = 1'b1;
        else if (diff > `SOS_ARRIVE_HYST)
            n.arrival = 1'b0;
        // above the level sets, only more than a full hysteresis step below clears
        if (det.out_freq > det.freq_detect_level)
            n.fdet = 1'b1;
        else if ({1'b0, det.out_freq} + {1'b0, `SOS_FDET_HYST} < {1'b0, det.freq_detect_level})
            n.fdet = 1'b0;
        // over-current: any dip below the level restarts the timing
        if (det.current > det.current_detect_level)
        begin
            if (q.oc_cnt >= det.current_detect_timer)
                n.oc_det = 1'b1;
            else if (tick)
                n.oc_cnt = 16'(q.oc_cnt + 1'b1);
        end
        else
        begin
            n.oc_cnt = 16'h0000;
            n.oc_det = 1'b0;
        end
        // under-current, same timing
        if (det.current < det.current_detect_level)
        begin
            if (q.uc_cnt >= det.current_detect_timer)
                n.uc_det = 1'b1;
            else if (tick)
                n.uc_cnt = 16'(q.uc_cnt + 1'b1);
        end
        else
        begin
            n.uc_cnt = 16'h0000;
            n.uc_det = 1'b0;
        end
    end

    // state register
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
            q <= '0;
        else
            q <= n;
    end

    assign det.freq_arrival = q.arrival;
    assign det.freq_level_detect = q.fdet;
    assign det.overcurrent_timed_detect = q.oc_det;
    assign det.undercurrent_timed_detect = q.uc_det;

endmodule : sos_detect

`default_nettype wire

// ===== rtl/sos_top.sv
// status output selector: picks one drive condition for the transistor output terminal
`include "sos_defines.svh"
`default_nettype none

module sos_top #(
    parameter int TICK_CYCLES = `SOS_TICK_CYCLES // cycles per current timer unit (1 ms)
) (
    input wire logic mclk_i, // system clock, 10 MHz
    input wire logic nrst_i, // synchronous reset, active low
    input wire logic [`SOS_ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic [2:0] s_axi_awprot, // write protection, unused
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [`SOS_ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic [2:0] s_axi_arprot, // read protection, unused
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [15:0] out_freq_i, // output frequency, 0.1 Hz units
    input wire logic [15:0] set_freq_i, // set frequency, 0.1 Hz units
    input wire logic run_cmd_i, // run command active
    input wire logic gate_drive_on_i, // power stage gate enabled
    input wire logic undervoltage_stop_i, // output halted by undervoltage
    input wire logic current_limiting_active_i, // current limiter restricting
    input wire logic auto_restart_active_i, // power failure until restart done
    input wire logic [15:0] thermal_value_i, // motor thermal model value
    input wire logic auto_reset_active_i, // automatic fault reset in progress
    input wire logic service_age_alarm_i, // lifetime threshold crossed
    input wire logic overload_avoidance_active_i, // overload avoidance acting
    input wire logic [15:0] current_i, // output current
    input wire logic any_fault_alarm_i, // alarm relay condition
    output logic transistor_output_terminal_o, // terminal drive, registered
    output logic irq_o // level interrupt
);

    // ****************************************
    // state and wires
    // ****************************************
    sos_pkg::sos_top_st_t q;
    sos_pkg::sos_top_st_t n;
    sos_det_if det ();
    logic [`SOS_EVT_W-1:0] evt_now;
    logic [`SOS_EVT_W-1:0] evt_clr;
    logic [31:0] wr_word;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;
    logic sel_active;
    logic sel_valid;
    logic thermal_warning;

    // detector inputs from the drive and from software settings
    assign det.out_freq = out_freq_i;
    assign det.set_freq = set_freq_i;
    assign det.run_cmd = run_cmd_i;
    assign det.current = current_i;
    assign det.freq_detect_level = q.freq_detect_level;
    assign det.current_detect_level = q.current_detect_level;
    assign det.current_detect_timer = q.current_detect_timer;

    sos_detect #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_detect (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .det(det)
    );

    // ****************************************
    // source selection
    // ****************************************
    assign thermal_warning = (thermal_value_i > q.thermal_warn_level);

    // one source per code; anything unlisted is not a source at all
    always_comb
    begin
        sel_active = 1'b0;
        sel_valid = 1'b1;
        case (q.sel)
            `SOS_SEL_RUNNING: sel_active = (out_freq_i > q.start_freq);
            `SOS_SEL_GATE_ON: sel_active = gate_drive_on_i;
            `SOS_SEL_FREQ_ARRIVAL: sel_active = det.freq_arrival;
            `SOS_SEL_FREQ_LEVEL: sel_active = det.freq_level_detect;
            `SOS_SEL_UNDERVOLTAGE: sel_active = undervoltage_stop_i & run_cmd_i;
            `SOS_SEL_CURRENT_LIMIT: sel_active = current_limiting_active_i;
            `SOS_SEL_AUTO_RESTART: sel_active = auto_restart_active_i;
            `SOS_SEL_THERMAL_WARN: sel_active = thermal_warning;
            `SOS_SEL_AUTO_RESET: sel_active = auto_reset_active_i;
            `SOS_SEL_SERVICE_AGE: sel_active = service_age_alarm_i;
            `SOS_SEL_OVERLOAD_AVOID: sel_active = overload_avoidance_active_i;
            `SOS_SEL_OVERCURRENT: sel_active = det.overcurrent_timed_detect;
            `SOS_SEL_UNDERCURRENT: sel_active = det.undercurrent_timed_detect;
            `SOS_SEL_ANY_FAULT: sel_active = any_fault_alarm_i;
            default: sel_valid = 1'b0;
        endcase
    end

    // ****************************************
    // register read decode
    // ****************************************
    // unmapped offsets answer with an error and zero data
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `SOS_OFS_CTRL:
            begin
                rd_word[`SOS_CTRL_SEL_LSB +: `SOS_SEL_W] = q.sel;
                rd_word[`SOS_CTRL_INV_BIT] = q.inv;
            end
            `SOS_OFS_START_FREQ: rd_word[15:0] = q.start_freq;
            `SOS_OFS_FREQ_DETECT_LEVEL: rd_word[15:0] = q.freq_detect_level;
            `SOS_OFS_CURRENT_DETECT_LEVEL: rd_word[15:0] = q.current_detect_level;
            `SOS_OFS_CURRENT_DETECT_TIMER: rd_word[15:0] = q.current_detect_timer;
            `SOS_OFS_THERMAL_WARN_LEVEL: rd_word[15:0] = q.thermal_warn_level;
            `SOS_OFS_EVENT_STATUS: rd_word[`SOS_EVT_W-1:0] = q.evt_status;
            `SOS_OFS_EVENT_MASK: rd_word[`SOS_EVT_W-1:0] = q.evt_mask;
            `SOS_OFS_LIVE_STATUS:
            begin
                rd_word[`SOS_LIVE_ACTIVE] = q.active;
                rd_word[`SOS_LIVE_TERMINAL] = q.terminal;
                rd_word[`SOS_LIVE_ARRIVAL] = det.freq_arrival;
                rd_word[`SOS_LIVE_FREQ_DET] = det.freq_level_detect;
                rd_word[`SOS_LIVE_OVERCUR] = det.overcurrent_timed_detect;
                rd_word[`SOS_LIVE_UNDERCUR] = det.undercurrent_timed_detect;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        n = q;
        evt_clr = '0;
        wr_hit = 1'b1;
        wr_word = 32'h0000_0000;
        // address and data are caught separately, in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            n.aw_have = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            n.w_have = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        // register write once both halves are held
        if (q.wr_st == sos_pkg::WR_IDLE && q.aw_have && q.w_have)
        begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.wr_st = sos_pkg::WR_RESP;
            case (q.awaddr)
                `SOS_OFS_CTRL:
                begin
                    wr_word = sos_pkg::sos_merge({23'h000000, q.inv, 1'b0, q.sel}, q.wdata, q.wstrb);
                    n.sel = wr_word[`SOS_CTRL_SEL_LSB +: `SOS_SEL_W];
                    n.inv = wr_word[`SOS_CTRL_INV_BIT];
                end
                `SOS_OFS_START_FREQ:
                begin
                    wr_word = sos_pkg::sos_merge({16'h0000, q.start_freq}, q.wdata, q.wstrb);
                    n.start_freq = wr_word[15:0];
                end
                `SOS_OFS_FREQ_DETECT_LEVEL:
                begin
                    wr_word = sos_pkg::sos_merge({16'h0000, q.freq_detect_level}, q.wdata, q.wstrb);
                    n.freq_detect_level = wr_word[15:0];
                end
                `SOS_OFS_CURRENT_DETECT_LEVEL:
                begin
                    wr_word = sos_pkg::sos_merge({16'h0000, q.current_detect_level}, q.wdata, q.wstrb);
                    n.current_detect_level = wr_word[15:0];
                end
                `SOS_OFS_CURRENT_DETECT_TIMER:
                begin
                    wr_word = sos_pkg::sos_merge({16'h0000, q.current_detect_timer}, q.wdata, q.wstrb);
                    n.current_detect_timer = wr_word[15:0];
                end
                `SOS_OFS_THERMAL_WARN_LEVEL:
                begin
                    wr_word = sos_pkg::sos_merge({16'h0000, q.thermal_warn_level}, q.wdata, q.wstrb);
                    n.thermal_warn_level = wr_word[15:0];
                end
                `SOS_OFS_EVENT_STATUS:
                begin
                    wr_word = sos_pkg::sos_merge(32'h0000_0000, q.wdata, q.wstrb);
                    evt_clr = wr_word[`SOS_EVT_W-1:0];
                end
                `SOS_OFS_EVENT_MASK:
                begin
                    wr_word = sos_pkg::sos_merge({28'h0000000, q.evt_mask}, q.wdata, q.wstrb);
                    n.evt_mask = wr_word[`SOS_EVT_W-1:0];
                end
                `SOS_OFS_LIVE_STATUS: wr_hit = 1'b1; // read only, write ignored
                default: wr_hit = 1'b0;
            endcase
            n.bresp = wr_hit ? 2'h0 : 2'h2;
        end
        else if (q.wr_st == sos_pkg::WR_RESP && s_axi_bready)
        begin
            n.wr_st = sos_pkg::WR_IDLE;
        end
        // read: data is latched with the address, held until taken
        if (q.rd_st == sos_pkg::RD_IDLE && s_axi_arvalid)
        begin
            n.rd_st = sos_pkg::RD_RESP;
            n.rdata = rd_word;
            n.rresp = rd_hit ? 2'h0 : 2'h2;
        end
        else if (q.rd_st == sos_pkg::RD_RESP && s_axi_rready)
        begin
            n.rd_st = sos_pkg::RD_IDLE;
        end
        // selected source, polarity and glitch-free terminal
        n.active = sel_valid & sel_active;
        n.terminal = sel_valid ? (sel_active ^ q.inv) : 1'b0;
        // rising edges are events; a new event beats a clear in the same cycle
        evt_now[`SOS_EVT_SELECTED] = n.active;
        evt_now[`SOS_EVT_OVERCUR] = det.overcurrent_timed_detect;
        evt_now[`SOS_EVT_UNDERCUR] = det.undercurrent_timed_detect;
        evt_now[`SOS_EVT_FAULT] = any_fault_alarm_i;
        n.evt_prev = evt_now;
        n.evt_status = (q.evt_status & ~evt_clr) | (evt_now & ~q.evt_prev);
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            q <= '0;
            q.wr_st <= sos_pkg::WR_IDLE;
            q.rd_st <= sos_pkg::RD_IDLE;
            q.sel <= `SOS_RST_SEL;
            q.inv <= `SOS_RST_INV;
            q.start_freq <= `SOS_RST_VAL;
            q.evt_status <= `SOS_RST_EVT;
            q.evt_mask <= `SOS_RST_EVT;
        end
        else
        begin
            q <= n;
        end
    end

    // bus handshakes from state, data from flip-flops
    assign s_axi_awready = ~q.aw_have;
    assign s_axi_wready = ~q.w_have;
    assign s_axi_bvalid = (q.wr_st == sos_pkg::WR_RESP);
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = (q.rd_st == sos_pkg::RD_IDLE);
    assign s_axi_rvalid = (q.rd_st == sos_pkg::RD_RESP);
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign transistor_output_terminal_o = q.terminal;
    assign irq_o = |(q.evt_status & q.evt_mask);

endmodule : sos_top

`default_nettype wire

// ===== verification/sos_checker.sv
// assertion checker of the status output selector terminal
`default_nettype none
module sos_checker (
    input wire logic mclk_i, nrst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic gate_drive_on_i, current_limiting_active_i, auto_restart_active_i, auto_reset_active_i,
    input wire logic service_age_alarm_i, overload_avoidance_active_i, any_fault_alarm_i,
    input wire logic transistor_output_terminal_o, irq_o
);
    logic [8:0] sel_q;
    wire idle = s_axi_awready && s_axi_wready;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // shadow of the selector; tracked at the take edge, valid only while no write is held
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i) sel_q <= 9'h000;
        else if (s_axi_awvalid && s_axi_wvalid && idle && s_axi_awaddr == 8'h00) sel_q <= s_axi_wdata[8:0];
    end
    property p_src(logic [8:0] c, logic s);
        idle && sel_q == c |=> transistor_output_terminal_o == ($past(s) ^ c[8]);
    endproperty
    AST_GATE: assert property (p_src(9'h023, gate_drive_on_i)) else $error("gate drive not routed");
    AST_LIMIT: assert property (p_src(9'h005, current_limiting_active_i)) else $error("limit not routed");
    AST_RESTART: assert property (p_src(9'h006, auto_restart_active_i)) else $error("restart not routed");
    AST_RESET: assert property (p_src(9'h01A, auto_reset_active_i)) else $error("auto reset not routed");
    AST_AGE: assert property (p_src(9'h01E, service_age_alarm_i)) else $error("age alarm not routed");
    AST_AVOID: assert property (p_src(9'h024, overload_avoidance_active_i)) else $error("avoid not routed");
    AST_FAULT: assert property (p_src(9'h063, any_fault_alarm_i)) else $error("fault not routed");
    AST_INVERT: assert property (p_src(9'h123, gate_drive_on_i)) else $error("invert not applied");
    AST_UNUSED: assert property (idle && sel_q[6:0] == 7'h04 |=> !transistor_output_terminal_o)
        else $error("unassigned code drives terminal");
    cover property ($rose(transistor_output_terminal_o));
    cover property (irq_o);
    cover property (idle && sel_q == 9'h123);
endmodule : sos_checker
bind sos_top sos_checker i_chk (.*);
`default_nettype wire

// ===== verification/sos_plc_model.sv
// model of the controller digital input that watches the terminal
`default_nettype none
module sos_plc_model (
    input wire logic mclk_i, // controller scan clock
    input wire logic term_i, // terminal level
    output logic seen_o      // level latched by one input scan
);
    // one scan of delay, as a real input filter adds
    always_ff @(posedge mclk_i) seen_o <= term_i;
endmodule : sos_plc_model
`default_nettype wire

// ===== verification/tb_sos_top.sv
// self-checking bench of the status output selector
`default_nettype none
module tb_sos_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'b0, nrst_i = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, run = 1'b1, brdy = 1'b0, rrdy = 1'b0;
    logic awr, wrdy, bv, arr, rv, term, seen, irq;
    logic [1:0] bresp, rresp;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, src = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [15:0] ofreq = 16'h0, sfreq = 16'h0258, therm = 16'h0, cur = 16'h0;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    sos_top #(.TICK_CYCLES(4)) i_dut (.mclk_i, .nrst_i, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rrdy), .out_freq_i(ofreq), .set_freq_i(sfreq), .run_cmd_i(run),
        .gate_drive_on_i(src[0]), .undervoltage_stop_i(src[1]), .current_limiting_active_i(src[2]),
        .auto_restart_active_i(src[3]), .thermal_value_i(therm), .auto_reset_active_i(src[4]),
        .service_age_alarm_i(src[5]), .overload_avoidance_active_i(src[6]), .current_i(cur),
        .any_fault_alarm_i(src[7]), .transistor_output_terminal_o(term), .irq_o(irq));
    sos_plc_model i_plc (.mclk_i, .term_i(term), .seen_o(seen));
    always #50 mclk_i = ~mclk_i;
    // hang guard: far above the few hundred cycles the tests need
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk
    // bus master: each valid drops at the edge its own ready is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i) {awaddr, wdata, awv, wv, brdy} <= {a, d, 3'b111};
        do @(posedge mclk_i) {awv, wv} <= {awv & !awr, wv & !wrdy}; while ((awv && !awr) || (wv && !wrdy));
        do @(posedge mclk_i); while (!bv);
        brdy <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk_i) {araddr, arv, rrdy} <= {a, 2'b11};
        do @(posedge mclk_i); while (!arr);
        arv <= 1'b0;
        do @(posedge mclk_i); while (!rv);
        rrdy <= 1'b0;
        {d, r} = {rdata, rresp};
    endtask : rd
    task automatic look(input int n, input logic e);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
        chk(seen, e);
    endtask : look
    task automatic freq(input logic [15:0] f, input logic e);
        @(posedge mclk_i) ofreq <= f;
        look(4, e);
    endtask : freq
    task automatic test_levels();
        logic [31:0] d;
        logic [1:0] r;
        rd(8'h00, d, r);
        chk(d, 32'h0);
        rd(8'hF0, d, r);
        chk(r, 2'h2);
        wr(8'hF0, 32'h1);
        chk(bresp, 2'h2);
        wr(8'h04, 32'h64);
        freq(16'h0064, 1'b0);
        freq(16'h0065, 1'b1);
        wr(8'h08, 32'h1F4);
        wr(8'h00, 32'h2);
        freq(16'h01F5, 1'b1);
        freq(16'h01EF, 1'b1);
        freq(16'h01E9, 1'b0);
        wr(8'h00, 32'h1);
        freq(16'h0258, 1'b1);
        freq(16'h026C, 1'b1);
        freq(16'h0276, 1'b0);
        freq(16'h0258, 1'b1);
        @(posedge mclk_i) run <= 1'b0;
        look(4, 1'b0);
        @(posedge mclk_i) run <= 1'b1;
        wr(8'h14, 32'hC8);
        wr(8'h00, 32'h7);
        @(posedge mclk_i) therm <= 16'h00C9;
        look(4, 1'b1);
        @(posedge mclk_i) therm <= 16'h00C8;
        look(4, 1'b0);
        $display("test levels done");
    endtask : test_levels
    // each source alone, then every other source without it, in both polarities
    task automatic test_direct();
        logic [6:0] codes [8] = '{7'h23, 7'h03, 7'h05, 7'h06, 7'h1A, 7'h1E, 7'h24, 7'h63};
        for (int k = 0; k < 16; k++)
        begin
            wr(8'h00, {23'h0, k[3], 1'b0, codes[k[2:0]]});
            @(posedge mclk_i) src <= 8'h01 << k[2:0];
            look(4, !k[3]);
            @(posedge mclk_i) src <= ~(8'h01 << k[2:0]);
            look(4, k[3]);
        end
        wr(8'h00, 32'h104);
        @(posedge mclk_i) src <= 8'hFF;
        look(4, 1'b0);
        $display("test direct done");
    endtask : test_direct
    task automatic test_timed();
        logic [31:0] d;
        logic [1:0] r;
        wr(8'h0C, 32'h32);
        wr(8'h10, 32'h3);
        wr(8'h1C, 32'h6);
        for (int k = 0; k < 2; k++)
        begin
            wr(8'h00, k ? 32'h29 : 32'h25);
            @(posedge mclk_i) cur <= k ? 16'h0028 : 16'h003C;
            look(2, 1'b0);
            look(25, 1'b1);
            @(posedge mclk_i) cur <= 16'h0032;
            look(4, 1'b0);
        end
        chk(irq, 1'b1);
        wr(8'h18, 32'hF);
        rd(8'h18, d, r);
        chk(d, 32'h0);
        chk(irq, 1'b0);
        $display("test timed done");
    endtask : test_timed
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (10) @(posedge mclk_i);
        nrst_i <= 1'b1;
        test_levels();
        test_direct();
        test_timed();
        close_out();
    end
endmodule : tb_sos_top
`default_nettype wire
